/* File: design/hw_monitor_consts.vh */
`ifndef HW_MONITOR_CONSTS_VH
`define HW_MONITOR_CONSTS_VH

`define HWM_ADDR_STATUS_ONE   8'h41
`define HWM_ADDR_STATUS_TWO   8'h42
`define HWM_ADDR_MASK_TWO     8'h44
`define HWM_ADDR_COMPAT       8'h45
`define HWM_ADDR_CASE_CLR     8'h46
`define HWM_ADDR_VCODE_FAN    8'h47
`define HWM_ADDR_BUS_ADDR     8'h48
`define HWM_ADDR_VCODE_IDENT  8'h49
`define HWM_ADDR_TEMP_CFG     8'h4B

`define HWM_RST_MASK_TWO      8'h00
`define HWM_RST_COMPAT        8'h00
`define HWM_RST_CASE_CLR      7'h00
`define HWM_RST_FAN_DIV       4'h5
`define HWM_RST_ADDR_FIXED    5'h0B
`define HWM_RST_TEMP_CFG      7'h01
`define HWM_IDENT_DEFAULT     7'h00

`define HWM_MSK_PLUS12        0
`define HWM_MSK_CORE2         1
`define HWM_MSK_CASE          4
`define HWM_MSK_RESET_EN      7
`define HWM_CASE_CLR_BIT      7
`define HWM_ST1_TEMP          4

`define HWM_TMODE_ONCE        2'h1
`define HWM_TMODE_CMP         2'h2

`define HWM_PULSE_MS          20
`define HWM_CLK_KHZ           25000

`endif

/* File: design/low_pulse_timer.v */
`timescale 1ns/1ps
`default_nettype none
// holds a low pulse for a fixed count; restart requests while busy are ignored
module low_pulse_timer #(
   parameter         CYCLES = 500000
) (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   // control
   input  wire        start,
   output reg         active_ff,
   output reg         done_ff
);
   reg  [19:0] count_ff;

   always @(posedge clock) begin
      if (rst) begin
         active_ff <= 1'b0;
         done_ff   <= 1'b0;
         count_ff  <= 20'h00000;
      end else begin
         done_ff <= 1'b0;
         if (!active_ff) begin
            if (start) begin
               active_ff <= 1'b1;
               count_ff  <= CYCLES[19:0] - 20'h00001;
            end
         end else if (count_ff == 20'h00000) begin
            active_ff <= 1'b0;
            done_ff   <= 1'b1;
         end else begin
            count_ff <= count_ff - 20'h00001;
         end
      end
   end
endmodule
`default_nettype wire

/* File: design/temp_alarm.v */
`timescale 1ns/1ps
`default_nettype none
`include "hw_monitor_consts.vh"
module temp_alarm (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   // mode and measurement
   input  wire [1:0]  mode,
   input  wire        conv_done,
   input  wire        above_hot,
   input  wire        below_hyst,
   input  wire        status_rd,
   // flag
   output reg         flag_ff
);
   reg  hot_ff;
   reg  armed_ff;
   reg  nxt_flag;

   always @* begin
      nxt_flag = flag_ff;
      if (mode == `HWM_TMODE_CMP) begin
         nxt_flag = above_hot;
      end else begin
         if (status_rd)
            nxt_flag = 1'b0;
         // set after the clear so a same-cycle event is kept
         if (conv_done) begin
            if (mode == `HWM_TMODE_ONCE) begin
               if (above_hot && armed_ff)
                  nxt_flag = 1'b1;
            end else if (above_hot || (hot_ff && !below_hyst)) begin
               nxt_flag = 1'b1;
            end
         end
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         flag_ff  <= 1'b0;
         hot_ff   <= 1'b0;
         armed_ff <= 1'b1;
      end else begin
         flag_ff <= nxt_flag;
         if (conv_done) begin
            if (above_hot)
               hot_ff <= 1'b1;
            else if (below_hyst)
               hot_ff <= 1'b0;
            if (above_hot)
               armed_ff <= 1'b0;
            else if (below_hyst)
               armed_ff <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: design/hw_monitor_config_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "hw_monitor_consts.vh"
module hw_monitor_config_regs #(
   parameter         PULSE_CYCLES = `HWM_PULSE_MS * `HWM_CLK_KHZ,
   parameter [6:0]   IDENT_CODE   = `HWM_IDENT_DEFAULT  // arbitrary value
) (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   // register access
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata_ff,
   // main configuration register, held outside
   input  wire        cfg_int_enable,
   input  wire        cfg_reset_req,
   output reg         reset_started_ff,
   // strap and voltage code pins
   input  wire [3:0]  core_voltage_code,
   input  wire        core_voltage_code_bit4,
   input  wire        addr_strap_low,
   input  wire        addr_strap_high,
   // limit comparison results
   input  wire        plus12_err,
   input  wire        second_core_supply_err,
   input  wire        conv_done,
   input  wire        temp_above_hot,
   input  wire        temp_below_hyst,
   input  wire        temp_half_lsb,
   // chassis intrusion pin, open drain
   input  wire        case_open_in,
   output wire        case_open_oe,
   // reset pin, open drain
   output wire        reset_pin_oe,
   // interrupt pin, active low
   output reg         irq_n_ff,
   output reg         irq_oe_ff,
   // fan prescale and bus address
   output reg  [3:0]  tach_input_one_div_ff,
   output reg  [3:0]  tach_input_two_div_ff,
   output wire [6:0]  bus_address
);

   function [3:0] prescale_ratio;
      input [1:0] code;
      begin
         case (code)
            2'h0:    prescale_ratio = 4'h1;
            2'h1:    prescale_ratio = 4'h2;
            2'h2:    prescale_ratio = 4'h4;
            default: prescale_ratio = 4'h8;
         endcase
      end
   endfunction

   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // the three sources that mask two can gate, plus the temperature flag
   // temperature flag bypasses mask two, mask one sits outside this block
   function pending_irq;
      input [7:0] status;
      input [7:0] mask;
      input       temp;
      reg   [7:0] gated;
      begin
         gated       = status & ~mask &
                       ((8'h01 << `HWM_MSK_PLUS12) |
                        (8'h01 << `HWM_MSK_CORE2) |
                        (8'h01 << `HWM_MSK_CASE));
         pending_irq = (|gated) || temp;
      end
   endfunction

   // register storage
   reg  [7:0] interrupt_mask_two_ff;
   reg  [7:0] compat_spare_byte_ff;
   reg  [6:0] case_clr_spare_ff;
   reg        case_clr_ff;
   reg  [1:0] fan_one_code_ff;
   reg  [1:0] fan_two_code_ff;
   reg  [7:0] bus_address_reg_ff;
   reg  [6:0] ident_spare_ff;
   reg  [6:0] temperature_config_ff;
   reg  [7:0] status_two_ff;
   reg        case_prev_ff;

   reg  [7:0] nxt_status_two;
   reg  [7:0] nxt_rdata;
   reg        nxt_case_clr;
   reg        nxt_irq_oe;
   reg  [3:0] nxt_div_one;
   reg  [3:0] nxt_div_two;
   wire [3:0] fan_rst_code = `HWM_RST_FAN_DIV;

   wire       wr_mask   = reg_wr && hit(reg_addr, `HWM_ADDR_MASK_TWO);
   wire       wr_compat = reg_wr && hit(reg_addr, `HWM_ADDR_COMPAT);
   wire       wr_clr    = reg_wr && hit(reg_addr, `HWM_ADDR_CASE_CLR);
   wire       wr_fan    = reg_wr && hit(reg_addr, `HWM_ADDR_VCODE_FAN);
   wire       wr_baddr  = reg_wr && hit(reg_addr, `HWM_ADDR_BUS_ADDR);
   wire       wr_ident  = reg_wr && hit(reg_addr, `HWM_ADDR_VCODE_IDENT);
   wire       wr_tcfg   = reg_wr && hit(reg_addr, `HWM_ADDR_TEMP_CFG);
   wire       rd_st1    = reg_rd && hit(reg_addr, `HWM_ADDR_STATUS_ONE);
   wire       rd_st2    = reg_rd && hit(reg_addr, `HWM_ADDR_STATUS_TWO);

   wire       case_pulse_active;
   wire       case_pulse_done;
   wire       rst_pulse_active;
   wire       temp_flag;

   // a written 1 sets the bit, but starts no new pulse while one is running
   wire       case_start = wr_clr && reg_wdata[`HWM_CASE_CLR_BIT];
   wire       rst_start  = cfg_reset_req &&
                           interrupt_mask_two_ff[`HWM_MSK_RESET_EN];

   // our own low pulse would look like an intrusion edge, so ignore the pin then
   wire       case_rise  = case_open_in && !case_prev_ff && !case_pulse_active;

   // both pulses share one length, the minimum width at the nominal clock
   low_pulse_timer #(
      .CYCLES      (PULSE_CYCLES)
   ) u_case_pulse (
      .clock       (clock),
      .rst         (rst),
      .start       (case_start),
      .active_ff   (case_pulse_active),
      .done_ff     (case_pulse_done)
   );

   low_pulse_timer #(
      .CYCLES      (PULSE_CYCLES)
   ) u_reset_pulse (
      .clock       (clock),
      .rst         (rst),
      .start       (rst_start),
      .active_ff   (rst_pulse_active),
      .done_ff     ()
   );

   temp_alarm u_temp_alarm (
      .clock       (clock),
      .rst         (rst),
      .mode        (temperature_config_ff[1:0]),
      .conv_done   (conv_done),
      .above_hot   (temp_above_hot),
      .below_hyst  (temp_below_hyst),
      .status_rd   (rd_st1),
      .flag_ff     (temp_flag)
   );

   assign case_open_oe = case_pulse_active;
   assign reset_pin_oe = rst_pulse_active;
   assign bus_address  = bus_address_reg_ff[6:0];

   // status two: read clears what was returned, a new event wins over the clear
   always @* begin
      nxt_status_two = status_two_ff;
      if (rd_st2)
         nxt_status_two = 8'h00;
      if (plus12_err)
         nxt_status_two[`HWM_MSK_PLUS12] = 1'b1;
      if (second_core_supply_err)
         nxt_status_two[`HWM_MSK_CORE2] = 1'b1;
      if (case_rise)
         nxt_status_two[`HWM_MSK_CASE] = 1'b1;
   end

   // start wins, so a rewrite in the cycle the pulse ends is kept
   always @* begin
      nxt_case_clr = case_clr_ff;
      if (case_pulse_done)
         nxt_case_clr = 1'b0;
      if (case_start)
         nxt_case_clr = 1'b1;
   end

   // unmapped addresses read zero
   always @* begin
      nxt_rdata = 8'h00;
      if (hit(reg_addr, `HWM_ADDR_STATUS_ONE)) begin
         nxt_rdata[`HWM_ST1_TEMP] = temp_flag;
      end else if (hit(reg_addr, `HWM_ADDR_STATUS_TWO)) begin
         nxt_rdata = status_two_ff;
      end else if (hit(reg_addr, `HWM_ADDR_MASK_TWO)) begin
         nxt_rdata = interrupt_mask_two_ff;
      end else if (hit(reg_addr, `HWM_ADDR_COMPAT)) begin
         nxt_rdata = compat_spare_byte_ff;
      end else if (hit(reg_addr, `HWM_ADDR_CASE_CLR)) begin
         nxt_rdata = {case_clr_ff, case_clr_spare_ff};
      end else if (hit(reg_addr, `HWM_ADDR_VCODE_FAN)) begin
         nxt_rdata = {fan_two_code_ff, fan_one_code_ff, core_voltage_code};
      end else if (hit(reg_addr, `HWM_ADDR_BUS_ADDR)) begin
         nxt_rdata = bus_address_reg_ff;
      end else if (hit(reg_addr, `HWM_ADDR_VCODE_IDENT)) begin
         nxt_rdata = {ident_spare_ff, core_voltage_code_bit4};
      end else if (hit(reg_addr, `HWM_ADDR_TEMP_CFG)) begin
         nxt_rdata = {temp_half_lsb, temperature_config_ff};
      end else begin
         nxt_rdata = 8'h00;
      end
   end

   // interrupt mask two, compatibility byte, spare bits of the clear register
   always @(posedge clock) begin
      if (rst) begin
         interrupt_mask_two_ff <= `HWM_RST_MASK_TWO;
         compat_spare_byte_ff  <= `HWM_RST_COMPAT;
         case_clr_spare_ff     <= `HWM_RST_CASE_CLR;
      end else begin
         if (wr_mask)
            interrupt_mask_two_ff <= reg_wdata;
         if (wr_compat)
            compat_spare_byte_ff <= reg_wdata;
         if (wr_clr)
            case_clr_spare_ff <= reg_wdata[6:0];
      end
   end

   // fan prescale codes and bus address
   always @(posedge clock) begin
      if (rst) begin
         fan_one_code_ff       <= fan_rst_code[1:0];
         fan_two_code_ff       <= fan_rst_code[3:2];
         // straps are sampled by this clocked reset, not held afterwards
         bus_address_reg_ff    <= {1'b0, `HWM_RST_ADDR_FIXED,
                                   addr_strap_high, addr_strap_low};
      end else begin
         if (wr_fan) begin
            fan_one_code_ff <= reg_wdata[5:4];
            fan_two_code_ff <= reg_wdata[7:6];
         end
         // bit 7 is never written, so it keeps reading zero
         if (wr_baddr)
            bus_address_reg_ff[6:0] <= reg_wdata[6:0];
      end
   end

   // spare identification bits and temperature mode
   always @(posedge clock) begin
      if (rst) begin
         ident_spare_ff        <= IDENT_CODE;
         temperature_config_ff <= `HWM_RST_TEMP_CFG;
      end else begin
         if (wr_ident)
            ident_spare_ff <= reg_wdata[7:1];
         if (wr_tcfg)
            temperature_config_ff <= reg_wdata[6:0];
      end
   end

   // status, self-clearing bit, read data
   always @(posedge clock) begin
      if (rst) begin
         status_two_ff    <= 8'h00;
         case_clr_ff      <= 1'b0;
         case_prev_ff     <= 1'b0;
         reg_rdata_ff     <= 8'h00;
         reset_started_ff <= 1'b0;
      end else begin
         status_two_ff    <= nxt_status_two;
         case_clr_ff      <= nxt_case_clr;
         case_prev_ff     <= case_open_in;
         if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
         // tells the configuration register to drop its reset bit
         reset_started_ff <= rst_start && !rst_pulse_active;
      end
   end

   // next values of the interrupt pin and the prescale outputs
   always @* begin
      nxt_irq_oe  = cfg_int_enable &&
                    pending_irq(status_two_ff, interrupt_mask_two_ff,
                                temp_flag);
      nxt_div_one = prescale_ratio(fan_one_code_ff);
      nxt_div_two = prescale_ratio(fan_two_code_ff);
   end

   // interrupt pin and prescale outputs
   always @(posedge clock) begin
      if (rst) begin
         irq_n_ff              <= 1'b1;
         irq_oe_ff             <= 1'b0;
         tach_input_one_div_ff <= prescale_ratio(fan_rst_code[1:0]);
         tach_input_two_div_ff <= prescale_ratio(fan_rst_code[3:2]);
      end else begin
         irq_n_ff              <= !nxt_irq_oe;
         irq_oe_ff             <= nxt_irq_oe;
         tach_input_one_div_ff <= nxt_div_one;
         tach_input_two_div_ff <= nxt_div_two;
      end
   end

endmodule
`default_nettype wire

/* File: dv/hw_monitor_config_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module hw_monitor_config_regs_props #(
   parameter int PULSE_CYCLES = 8
) (
   // clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // register writes
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   // control and pins
   input wire logic       cfg_int_enable,
   input wire logic       cfg_reset_req,
   input wire logic       reset_started_ff,
   input wire logic       reset_pin_oe,
   input wire logic       case_open_oe,
   input wire logic       irq_n_ff,
   input wire logic       irq_oe_ff,
   input wire logic [3:0] tach_input_one_div_ff,
   input wire logic [3:0] tach_input_two_div_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [31:0] case_cnt_ff;
   logic [31:0] rpin_cnt_ff;
   // run lengths counted, pulses are too long to unroll
   always @(posedge clock) begin
      case_cnt_ff <= (rst || !case_open_oe) ? 32'h0 : case_cnt_ff + 32'h1;
      rpin_cnt_ff <= (rst || !reset_pin_oe) ? 32'h0 : rpin_cnt_ff + 32'h1;
   end
   case_start_a: assert property (
      reg_wr && reg_addr == 8'h46 && reg_wdata[7] && !case_open_oe |-> ##[1:2] case_open_oe)
      else $error("intrusion pulse not started");
   case_len_a: assert property (
      $fell(case_open_oe) && !$past(rst) |-> case_cnt_ff >= 32'(PULSE_CYCLES))
      else $error("intrusion pulse short");
   rpin_len_a: assert property (
      $fell(reset_pin_oe) && !$past(rst) |-> rpin_cnt_ff >= 32'(PULSE_CYCLES))
      else $error("reset pulse short");
   rpin_gate_a: assert property (
      $rose(reset_pin_oe) |-> $past(cfg_reset_req))
      else $error("reset pulse without request");
   rpin_flag_a: assert property (
      $rose(reset_pin_oe) |-> reset_started_ff ##1 !reset_started_ff)
      else $error("reset start flag wrong");
   irq_enable_a: assert property (
      !cfg_int_enable ##1 !cfg_int_enable |-> !irq_oe_ff)
      else $error("interrupt driven while disabled");
   irq_pair_a: assert property (
      irq_oe_ff |-> !irq_n_ff)
      else $error("interrupt driven high");
   div_one_a: assert property (
      tach_input_one_div_ff inside {4'h1, 4'h2, 4'h4, 4'h8})
      else $error("bad first divide ratio");
   div_two_a: assert property (
      tach_input_two_div_ff inside {4'h1, 4'h2, 4'h4, 4'h8})
      else $error("bad second divide ratio");
endmodule
bind hw_monitor_config_regs hw_monitor_config_regs_props #(
   .PULSE_CYCLES(PULSE_CYCLES)
) hw_monitor_config_regs_props_inst (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .cfg_int_enable(cfg_int_enable), .cfg_reset_req(cfg_reset_req),
   .reset_started_ff(reset_started_ff), .reset_pin_oe(reset_pin_oe),
   .case_open_oe(case_open_oe), .irq_n_ff(irq_n_ff), .irq_oe_ff(irq_oe_ff),
   .tach_input_one_div_ff(tach_input_one_div_ff), .tach_input_two_div_ff(tach_input_two_div_ff)
);
`default_nettype wire

/* File: dv/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock and answer
   input  wire logic       clock,
   input  wire logic [7:0] rdata,
   // requests
   output var logic [7:0]  addr,
   output var logic        wr,
   output var logic        rd,
   output var logic [7:0]  wdata
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // idle lines flip so a stale value is never mistaken for a request
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clock);
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      addr = a;
      rd = 1'b1;
      @(negedge clock);
      rd = 1'b0;
      addr = ~a;
      d = rdata;
   endtask
endmodule
`default_nettype wire

/* File: dv/hw_monitor_config_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hw_monitor_config_regs_tb_top;
   localparam int PULSE = 8;
   logic            clock = 1'b0;
   logic            rst = 1'b1;
   logic            int_en = 1'b0;
   logic            rst_req = 1'b0;
   logic            p12 = 1'b0;
   logic            core2 = 1'b0;
   logic            conv = 1'b0;
   logic            hot = 1'b0;
   logic            cool = 1'b0;
   logic            half = 1'b1;
   logic            case_ext = 1'b0;
   wire logic [7:0] addr;
   wire logic       wr;
   wire logic       rd;
   wire logic [7:0] wdata;
   wire logic [7:0] rdata;
   wire logic       started;
   wire logic       case_oe;
   wire logic       rpin_oe;
   wire logic       irq_n;
   wire logic       irq_oe;
   wire logic [3:0] div_one;
   wire logic [3:0] div_two;
   wire logic [6:0] bus_addr;
   // open drain: the device pull wins
   wire logic       case_in = case_ext & ~case_oe;
   int              n_mismatch = 0;
   int              check_count = 0;
   int              cycles = 0;
   always #20 clock = ~clock;
   hw_monitor_config_regs #(.PULSE_CYCLES(PULSE)) hw_monitor_config_regs_inst (
      .clock(clock), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
      .reg_wdata(wdata), .reg_rdata_ff(rdata), .cfg_int_enable(int_en),
      .cfg_reset_req(rst_req), .reset_started_ff(started), .core_voltage_code(4'hA),
      .core_voltage_code_bit4(1'b1), .addr_strap_low(1'b0), .addr_strap_high(1'b1),
      .plus12_err(p12), .second_core_supply_err(core2), .conv_done(conv),
      .temp_above_hot(hot), .temp_below_hyst(cool), .temp_half_lsb(half),
      .case_open_in(case_in), .case_open_oe(case_oe), .reset_pin_oe(rpin_oe),
      .irq_n_ff(irq_n), .irq_oe_ff(irq_oe), .tach_input_one_div_ff(div_one),
      .tach_input_two_div_ff(div_two), .bus_address(bus_addr)
   );
   host_model host_model_inst (
      .clock(clock), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata)
   );
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      host_model_inst.write(a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_model_inst.read(a, d);
      chk(d, e);
   endtask
   task automatic wchk(input logic [7:0] a, input logic [7:0] w, input logic [7:0] e);
      wreg(a, w);
      rchk(a, e);
   endtask
   // one-cycle event: 0 plus12, 1 core two, 3 conversion; 2 raises the intrusion pin and leaves it high
   task automatic ev(input int k);
      @(negedge clock);
      p12 = (k == 0);
      core2 = (k == 1);
      conv = (k == 3);
      if (k == 2) case_ext = 1'b1;
      @(negedge clock);
      p12 = 1'b0;
      core2 = 1'b0;
      conv = 1'b0;
   endtask
   task automatic run_len(input logic sel, input logic [7:0] e);
      int n;
      int w;
      n = 0;
      w = 0;
      while ((sel ? rpin_oe : case_oe) !== 1'b1 && w < 4) begin
         w++;
         @(negedge clock);
      end
      if (sel) chk({7'h0, started}, 8'h01);
      rst_req = 1'b0;
      while ((sel ? rpin_oe : case_oe) === 1'b1 && n < 60) begin
         n++;
         @(negedge clock);
      end
      chk(8'(n), e);
   endtask
   task automatic t_reset();
      rchk(8'h44, 8'h00);
      rchk(8'h45, 8'h00);
      rchk(8'h46, 8'h00);
      rchk(8'h47, 8'h5A);
      rchk(8'h48, 8'h2E);
      rchk(8'h49, 8'h01);
      rchk(8'h4B, 8'h81);
      rchk(8'h4A, 8'h00);
      chk({div_two, div_one}, 8'h22);
   endtask
   task automatic t_rw();
      half = 1'b0;
      wchk(8'h44, 8'h5A, 8'h5A);
      wchk(8'h45, 8'hA5, 8'hA5);
      wchk(8'h46, 8'h2A, 8'h2A);
      wchk(8'h48, 8'hFF, 8'h7F);
      chk({1'b0, bus_addr}, 8'h7F);
      wchk(8'h49, 8'hFE, 8'hFF);
      wchk(8'h4B, 8'hFD, 8'h7D);
      wchk(8'h4A, 8'h55, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wchk(8'h47, {2'(3 - c), 2'(c), 4'h0}, {2'(3 - c), 2'(c), 4'hA});
         chk({div_two, div_one}, {4'h8 >> c, 4'h1 << c});
      end
      wreg(8'h44, 8'h00);
      wreg(8'h46, 8'h00);
      wreg(8'h4B, 8'h01);
   endtask
   task automatic t_case();
      wreg(8'h46, 8'h80);
      run_len(1'b0, 8'(PULSE));
      cyc(2);
      rchk(8'h46, 8'h00);
   endtask
   task automatic t_mask();
      logic [7:0] b;
      int_en = 1'b1;
      for (int k = 0; k < 3; k++) begin
         b = (k == 2) ? 8'h10 : 8'h01 << k;
         for (int m = 0; m < 2; m++) begin
            wreg(8'h44, m ? b : 8'h00);
            ev(k);
            cyc(3);
            chk({6'h0, irq_oe, irq_n}, m ? 8'h01 : 8'h02);
            rchk(8'h42, b);
            cyc(3);
            chk({7'h0, irq_n}, 8'h01);
            case_ext = 1'b0;
         end
      end
      int_en = 1'b0;
      wreg(8'h44, 8'h00);
      ev(0);
      cyc(3);
      chk({7'h0, irq_oe}, 8'h00);
      rchk(8'h42, 8'h01);
   endtask
   task automatic t_rpin();
      rst_req = 1'b1;
      cyc(4);
      chk({7'h0, rpin_oe}, 8'h00);
      wreg(8'h44, 8'h80);
      run_len(1'b1, 8'(PULSE));
      wreg(8'h44, 8'h00);
   endtask
   task automatic t_temp();
      int_en = 1'b1;
      wreg(8'h4B, 8'h02);
      hot = 1'b1;
      cyc(3);
      chk({7'h0, irq_n}, 8'h00);
      hot = 1'b0;
      cyc(3);
      chk({7'h0, irq_n}, 8'h01);
      wreg(8'h4B, 8'h01);
      hot = 1'b1;
      ev(3);
      cyc(2);
      chk({7'h0, irq_n}, 8'h00);
      rchk(8'h41, 8'h10);
      ev(3);
      rchk(8'h41, 8'h00);
      hot = 1'b0;
      cool = 1'b1;
      ev(3);
      hot = 1'b1;
      cool = 1'b0;
      ev(3);
      rchk(8'h41, 8'h10);
      for (int m = 0; m < 4; m += 3) begin
         wreg(8'h4B, 8'(m));
         ev(3);
         rchk(8'h41, 8'h10);
         hot = 1'b0;
         ev(3);
         rchk(8'h41, 8'h10);
         cool = 1'b1;
         ev(3);
         rchk(8'h41, 8'h00);
         cool = 1'b0;
         hot = 1'b1;
      end
   endtask
   // whole run is well under a thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      cyc(8);
      rst = 1'b0;
      t_reset();
      t_rw();
      t_case();
      t_mask();
      t_rpin();
      t_temp();
      wrap_up();
   end
endmodule
`default_nettype wire
